// >>> hw/rxo_pkg.sv
// Package for the receive options register bank: map, fields, reset values
package rxo_pkg;
  localparam logic [7:0] RXO_ADDR_RECEIVE_OPTIONS = 8'h00;
  localparam int RXO_ADDR_TEST_BIT = 7;
  localparam int RXO_BIT_UNFRAMED = 6;
  localparam int RXO_BIT_ES_BYPASS = 5;
  localparam int RXO_BIT_SLIP_CLK = 4;
  localparam int RXO_BIT_RAW_PCM = 3;
  localparam int RXO_BIT_SF_PULSE = 2;
  localparam int RXO_BIT_ALT_SUPP = 1;
  localparam int RXO_BIT_FRAME_ALIGNMENT_CHANGE_CNT = 0;
  localparam logic [7:0] RXO_WR_MASK = 8'h7F;
  localparam logic [7:0] RXO_RESET = 8'h00;
  localparam logic [7:0] RXO_UNUSED_READ = 8'h00;
endpackage : rxo_pkg

// >>> hw/rxo_regs.sv
// Receive options register with normal-mode address decode and control outputs
`timescale 1ns/1ps
// How it works
// - Address bit seven low selects normal registers; 80H-FFH belong to test space.
// - Writes to unused bit positions change nothing.
// - Every writable bit reads back the value last written.
// - Reset clears every writable bit to zero.
// - Offset 00H: bit6 unframed, 5 bypass, 4 slip clock, 3 raw PCM, 2 SF, 1 alt, 0 count.
// - Unframed mode disables the frame aligner; data passes without alignment.
// - Alarm integrator keeps running while unframed mode is set.
// - Unframed mode zero lets the frame aligner search normally.
// - Bypass routes elastic store inputs straight to outputs.
// - Slip clock select one feeds transmitter clock to the store system side.
// - Slip clock select zero feeds backplane receive clock to the system side.
// - Slip clock selection acts only while bypass is set.
// - Raw PCM select picks undecoded PCM at one, decoded PCM at zero.
// - Frame pulse every framing bit, or only at superframe start when selected.
// - Alternate suppress drops every second frame pulse.
// - Count select one counts alignment changes, zero counts out-of-frame events.
module rxo_regs
  import rxo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic frame_aligner_en_o,
  output logic alarm_integrator_en_o,
  output logic elastic_store_bypass_o,
  output logic slip_clk_from_tx_o,
  output logic raw_pcm_select_o,
  output logic superframe_pulse_select_o,
  output logic alternate_pulse_suppress_o,
  output logic alignment_change_count_select_o
);
  import rxo_pkg::*;

  typedef enum logic [1:0] {RXO_IDLE = 2'b00, RXO_ACK = 2'b01} rxo_state_t;

  logic [7:0] opt_ff;
  logic [7:0] nxt_opt;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  rxo_state_t st_ff;
  rxo_state_t nxt_st;
  logic aligner_en_ff;
  logic nxt_aligner_en;
  logic alarm_en_ff;
  logic nxt_alarm_en;
  logic slip_tx_ff;
  logic nxt_slip_tx;

  // Decode of the single register, normal space only
  function automatic logic rxo_hit(input logic [7:0] a);
    rxo_hit = !a[RXO_ADDR_TEST_BIT] && (a == RXO_ADDR_RECEIVE_OPTIONS);
  endfunction : rxo_hit

  // Next register, read data and access state
  always_comb
  begin
    nxt_opt = opt_ff;
    nxt_rdata = rdata_ff;
    nxt_st = st_ff;
    case (st_ff)
      RXO_IDLE:
      begin
        if (cs_i && wr_i && rxo_hit(addr_i))
        begin
          nxt_opt = wdata_i & RXO_WR_MASK;
          nxt_st = RXO_ACK;
        end
        if (cs_i && rd_i)
        begin
          // Unused bit reads as zero; unmapped addresses return zero
          nxt_rdata = rxo_hit(addr_i) ? ((opt_ff & RXO_WR_MASK) | RXO_UNUSED_READ)
                                      : 8'h00;
        end
      end
      RXO_ACK:
        nxt_st = RXO_IDLE;
      default:
        nxt_st = RXO_IDLE;
    endcase
    // Derived controls follow the next register value so they land with it
    nxt_aligner_en = !nxt_opt[RXO_BIT_UNFRAMED];
    // The integrator is independent of framing mode and is never switched off
    nxt_alarm_en = 1'b1;
    // Substitution is gated by bypass so a stray select cannot disturb the store
    nxt_slip_tx = nxt_opt[RXO_BIT_SLIP_CLK] & nxt_opt[RXO_BIT_ES_BYPASS];
  end

  // Registers; the control flops load from the next value so they land with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      opt_ff <= RXO_RESET;
      rdata_ff <= 8'h00;
      st_ff <= RXO_IDLE;
      aligner_en_ff <= !RXO_RESET[RXO_BIT_UNFRAMED];
      alarm_en_ff <= 1'b1;
      slip_tx_ff <= RXO_RESET[RXO_BIT_SLIP_CLK] & RXO_RESET[RXO_BIT_ES_BYPASS];
    end
    else
    begin
      opt_ff <= nxt_opt;
      rdata_ff <= nxt_rdata;
      st_ff <= nxt_st;
      aligner_en_ff <= nxt_aligner_en;
      alarm_en_ff <= nxt_alarm_en;
      slip_tx_ff <= nxt_slip_tx;
    end
  end

  // Outputs come straight from flops so downstream selects see no decode glitches
  assign rdata_o = rdata_ff;
  assign frame_aligner_en_o = aligner_en_ff;
  assign alarm_integrator_en_o = alarm_en_ff;
  assign elastic_store_bypass_o = opt_ff[RXO_BIT_ES_BYPASS];
  assign slip_clk_from_tx_o = slip_tx_ff;
  assign raw_pcm_select_o = opt_ff[RXO_BIT_RAW_PCM];
  assign superframe_pulse_select_o = opt_ff[RXO_BIT_SF_PULSE];
  assign alternate_pulse_suppress_o = opt_ff[RXO_BIT_ALT_SUPP];
  assign alignment_change_count_select_o = opt_ff[RXO_BIT_FRAME_ALIGNMENT_CHANGE_CNT];

  // A completed write reaches the bypass control on the next cycle
  AST_WRITE_TAKES: assert property (@(posedge clk_i) disable iff (rst_i)
    (cs_i && wr_i && rxo_hit(addr_i) && st_ff == RXO_IDLE) |=>
      (elastic_store_bypass_o == $past(wdata_i[RXO_BIT_ES_BYPASS])))
    else $error("bypass did not follow write");

  // The whole stored byte is the written byte with the unused bit dropped
  AST_WRITE_VALUE: assert property (@(posedge clk_i) disable iff (rst_i)
    (cs_i && wr_i && rxo_hit(addr_i) && st_ff == RXO_IDLE) |=>
      (opt_ff == ($past(wdata_i) & RXO_WR_MASK)))
    else $error("stored byte differs from write");

  // Nothing the processor writes can set the unused bit
  AST_UNUSED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    opt_ff[7] == 1'b0)
    else $error("unused bit stored");

  // Reset leaves the register clear on the following edge
  AST_RESET_CLEAR: assert property (@(posedge clk_i) rst_i |=> opt_ff == 8'h00)
    else $error("reset did not clear");

  // Reset also restores the derived controls to their cleared meaning
  AST_RESET_CONTROLS: assert property (@(posedge clk_i) rst_i |=>
    (frame_aligner_en_o && alarm_integrator_en_o && !slip_clk_from_tx_o))
    else $error("controls not cleared by reset");

  // Test space accesses never touch the register
  AST_TEST_SPACE: assert property (@(posedge clk_i) disable iff (rst_i)
    (addr_i[7] && !rst_i) |=> $stable(opt_ff))
    else $error("test space write changed register");

  // Writes to any other normal address leave this register alone
  AST_OTHER_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    (cs_i && wr_i && !rxo_hit(addr_i)) |=> $stable(opt_ff))
    else $error("foreign write changed register");

  // A read returns the value held when the read was taken
  AST_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
    (cs_i && rd_i && st_ff == RXO_IDLE && rxo_hit(addr_i)) |=>
      rdata_o == $past(opt_ff))
    else $error("readback mismatch");

  // Addresses this block does not own read back as zero
  AST_UNMAPPED_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (cs_i && rd_i && st_ff == RXO_IDLE && !rxo_hit(addr_i)) |=>
      rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // Read data stands until the next read
  AST_READ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cs_i && rd_i) |=> $stable(rdata_o))
    else $error("read data changed without read");

  // Aligner runs exactly when unframed mode is clear
  AST_ALIGNER: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_aligner_en_o != opt_ff[RXO_BIT_UNFRAMED])
    else $error("aligner enable wrong");

  // Transmit clock never reaches the store unless it is bypassed
  AST_SLIP_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    !elastic_store_bypass_o |-> !slip_clk_from_tx_o)
    else $error("slip clock without bypass");

  // With bypass and select both set the transmit clock is substituted
  AST_SLIP_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    (opt_ff[RXO_BIT_SLIP_CLK] && opt_ff[RXO_BIT_ES_BYPASS]) |-> slip_clk_from_tx_o)
    else $error("transmit clock not substituted");

  // Select clear keeps the backplane receive clock on the system side
  AST_SLIP_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !opt_ff[RXO_BIT_SLIP_CLK] |-> !slip_clk_from_tx_o)
    else $error("backplane clock not selected");

  // Without a write strobe the register holds
  AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cs_i && wr_i) |=> $stable(opt_ff))
    else $error("register changed without write");

  // A write arriving in the acknowledge cycle is refused
  AST_ACK_REFUSES: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == RXO_ACK) |=> $stable(opt_ff))
    else $error("write accepted in acknowledge cycle");

  // The alarm integrator is never switched off, framed or not
  AST_ALARM_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    alarm_integrator_en_o)
    else $error("alarm integrator stopped");

  // Main scenarios: write, read, substitution, unframed, refused second write
  COV_WRITE: cover property (@(posedge clk_i) cs_i && wr_i && rxo_hit(addr_i));
  COV_READ: cover property (@(posedge clk_i) cs_i && rd_i && rxo_hit(addr_i));
  COV_SLIP: cover property (@(posedge clk_i) slip_clk_from_tx_o);
  COV_UNFRAMED: cover property (@(posedge clk_i) !frame_aligner_en_o);
  COV_ACK_WRITE: cover property (@(posedge clk_i) st_ff == RXO_ACK && cs_i && wr_i);
endmodule : rxo_regs

// >>> tb/rxo_regs_tb_top.sv
// Self-checking bench for the receive options register bank
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module rxo_regs_tb_top;
  import rxo_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic [7:0] ctl;
  int error_cnt = 0;
  int num_checks = 0;
  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;
  rxo_regs rxo_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .cs_i(cs_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .frame_aligner_en_o(ctl[7]),
    .alarm_integrator_en_o(ctl[6]), .elastic_store_bypass_o(ctl[5]),
    .slip_clk_from_tx_o(ctl[4]), .raw_pcm_select_o(ctl[3]),
    .superframe_pulse_select_o(ctl[2]), .alternate_pulse_suppress_o(ctl[1]),
    .alignment_change_count_select_o(ctl[0]));
  // Controls expected from a stored value; slip clock only counts under bypass
  function automatic logic [7:0] exp_ctl(input logic [7:0] v);
    return {~v[6], 1'b1, v[5], v[4] & v[5], v[3:0]};
  endfunction : exp_ctl
  // Write, then the idle cycle the access state needs before the next write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    cs_i = 1'b1;
    wr_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    @(negedge clk_i);
    cs_i = 1'b0;
    wr_i = 1'b0;
    @(negedge clk_i);
  endtask : wr
  // Read; data is registered, so look one cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    cs_i = 1'b1;
    rd_i = 1'b1;
    addr_i = a;
    @(negedge clk_i);
    cs_i = 1'b0;
    rd_i = 1'b0;
    @(negedge clk_i);
    `CHK(rdata_o & RXO_WR_MASK, e)
  endtask : rd
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // Main sequence: reset state, each field alone, masks, foreign addresses, second reset
  initial
  begin
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    rd(RXO_ADDR_RECEIVE_OPTIONS, RXO_RESET);
    `CHK(ctl, exp_ctl(RXO_RESET))
    for (int b = 0; b < 7; b++)
    begin
      wr(RXO_ADDR_RECEIVE_OPTIONS, 8'h01 << b);
      `CHK(ctl, exp_ctl(8'h01 << b))
      rd(RXO_ADDR_RECEIVE_OPTIONS, 8'h01 << b);
    end
    wr(RXO_ADDR_RECEIVE_OPTIONS, 8'h30);
    `CHK(ctl, exp_ctl(8'h30))
    wr(RXO_ADDR_RECEIVE_OPTIONS, 8'hFF);
    rd(RXO_ADDR_RECEIVE_OPTIONS, RXO_WR_MASK);
    // Test space and other registers must not disturb the stored value
    wr(8'h80, 8'h00);
    `CHK(ctl, exp_ctl(RXO_WR_MASK))
    rd(8'h80, 8'h00);
    wr(8'h01, 8'h00);
    rd(RXO_ADDR_RECEIVE_OPTIONS, RXO_WR_MASK);
    wr(RXO_ADDR_RECEIVE_OPTIONS, 8'h20);
    `CHK(ctl, exp_ctl(8'h20))
    // A write held into the acknowledge cycle lands once; the repeat is refused
    @(negedge clk_i);
    cs_i = 1'b1;
    wr_i = 1'b1;
    addr_i = RXO_ADDR_RECEIVE_OPTIONS;
    wdata_i = 8'h08;
    @(negedge clk_i);
    wdata_i = 8'h04;
    @(negedge clk_i);
    cs_i = 1'b0;
    wr_i = 1'b0;
    `CHK(ctl, exp_ctl(8'h08))
    @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    `CHK(ctl, exp_ctl(RXO_RESET))
    rd(RXO_ADDR_RECEIVE_OPTIONS, RXO_RESET);
    tally_and_finish();
  end
  // Watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #50000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : rxo_regs_tb_top
